// >>> rtl/idle_wakeup_pkg.sv
package idle_wakeup_pkg;

    // ------------------------------------------------------------
    // Parameter byte positions within the idle command
    // ------------------------------------------------------------
    localparam int       PARAM_COUNT     = 14;
    localparam logic [3:0] IDX_WAKE_SRC  = 4'h0;
    localparam logic [3:0] IDX_ENTRY     = 4'h1;
    localparam logic [3:0] IDX_WAKE_CFG  = 4'h3;
    localparam logic [3:0] IDX_LEAVE     = 4'h5;
    localparam logic [3:0] IDX_PERIOD    = 4'h7;
    localparam logic [3:0] IDX_OSC_START = 4'h8;
    localparam logic [3:0] IDX_DAC_START = 4'h9;
    localparam logic [3:0] IDX_DAC_LOW   = 4'hA;
    localparam logic [3:0] IDX_DAC_HIGH  = 4'hB;
    localparam logic [3:0] IDX_SWING     = 4'hC;
    localparam logic [3:0] IDX_MAX_TRIAL = 4'hD;

    // ------------------------------------------------------------
    // Offsets inside a power pair, and the wake source offset
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_POWER_CONTROL_LOW  = 4'h0;
    localparam logic [3:0] OFS_POWER_CONTROL_HIGH = 4'h1;
    localparam logic [3:0] OFS_WAKE_SOURCE_SELECT = 4'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_COMPARE_IDX = 7;
    localparam int CTL_SLOW_OSC    = 5;
    localparam int CTL_FAST_OSC    = 4;
    localparam int CTL_ANALOGUE    = 3;
    localparam int CTL_HIBERNATE   = 2;
    localparam int CTL_SLEEP       = 0;
    localparam int CTH_FIELD_DET   = 1;
    localparam int CTH_CURRENT_REF = 0;
    localparam int WS_PRESC_HI     = 7;
    localparam int WS_PRESC_LO     = 6;
    localparam int WS_KEEP_LO      = 5;
    localparam int WS_SLAVE_SEL    = 4;
    localparam int WS_IRQ          = 3;
    localparam int WS_FIELD        = 2;
    localparam int WS_TAG          = 1;
    localparam int WS_TIMEOUT      = 0;
    localparam int THR_LO          = 2;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PARAM    = 8'h00;
    localparam logic [7:0] RST_WAKE_SRC = 8'h08;
    localparam logic [8:0] SLEEP_OFFSET = 9'h002;
    localparam int         SLEEP_SHIFT  = 8;  // 256 prescaled periods

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SLEEP,
        ST_OSC_WAIT,
        ST_DAC_WAIT,
        ST_BURST,
        ST_LEAVE
    } idle_state_t;

endpackage

// >>> rtl/idle_wakeup_controller.sv
// Contract
// - prescaler field divides slow oscillator by 1/2/4/8
// - wake byte bits 4..0 are separate sources
// - timeout bit wakes after max trials plus one sleep cycles
// - wake byte updated and returned on exit
// - low control bit 7 picks first threshold
// - bit 3 enables analogue supply
// - bit 2 hibernate, bit 0 sleep
// - high control bit 1 enables field detector
// - entry, wake and leave configurations applied
// - sleep lasts 256 prescaled periods times period+2
// - carrier on for swing count periods
// - timeout after max trials plus one cycles
// - compare only upper six threshold bits
// - response sent only on actual idle exit
`timescale 1ns/1ps
module idle_wakeup_controller
    import idle_wakeup_pkg::*;
#(
    parameter int SLEEP_CNT_W = 17,
    parameter int TRIAL_W     = 5
)(
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    input  wire logic       PARAM_WE,
    input  wire logic [3:0] PARAM_IDX,
    input  wire logic [7:0] PARAM_DATA,
    input  wire logic       START,
    input  wire logic       SLOW_TICK,
    input  wire logic       CARRIER_TICK,
    input  wire logic       SERIAL_SLAVE_SELECT_PIN_N,
    input  wire logic       IRQ_IN_N,
    input  wire logic       FIELD_DETECT,
    input  wire logic       TAG_VALID,
    input  wire logic [7:0] TAG_LEVEL,
    output logic            BUSY,
    output logic            SLOW_OSCILLATOR_EN,
    output logic            FAST_OSCILLATOR_EN,
    output logic            ANALOGUE_SUPPLY_ENABLE,
    output logic            HIBERNATE,
    output logic            SLEEP,
    output logic            FIELD_DETECTOR_EN,
    output logic            CURRENT_REFERENCE_ENABLE,
    output logic            RF_ON,
    output logic            COMPARE_SEL,
    output logic [5:0]      DAC_THRESHOLD,
    output logic            RESP_VALID,
    output logic [7:0]      RESP_DATA
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Mask of prescaler bits that must all be set for one tick
    function automatic logic [2:0] presc_mask(input logic [1:0] sel);
        logic [2:0] m;
        m = 3'h0;
        if (sel == 2'h1) begin
            m = 3'h1;
        end else if (sel == 2'h2) begin
            m = 3'h3;
        end else if (sel == 2'h3) begin
            m = 3'h7;
        end
        return m;
    endfunction

    // Count target of a sleep period in prescaled ticks
    function automatic logic [SLEEP_CNT_W-1:0] sleep_target(
        input logic [7:0] period);
        logic [8:0] mult;
        mult = {1'b0, period} + SLEEP_OFFSET;
        return SLEEP_CNT_W'({mult, 8'h00});
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]             param_ff [PARAM_COUNT];
    idle_state_t            state_ff;
    idle_state_t            nxt_state;
    logic [SLEEP_CNT_W-1:0] cnt_ff;
    logic [SLEEP_CNT_W-1:0] nxt_cnt;
    logic [TRIAL_W-1:0]     trial_ff;
    logic [TRIAL_W-1:0]     nxt_trial;
    logic [2:0]             presc_ff;
    logic [7:0]             cfg_low_ff;
    logic [7:0]             nxt_cfg_low;
    logic [7:0]             cfg_high_ff;
    logic [7:0]             nxt_cfg_high;
    logic                   cmp_sel_ff;
    logic                   nxt_cmp_sel;
    logic [4:0]             evt_ff;
    logic [4:0]             nxt_evt;
    logic                   rf_on_ff;
    logic [5:0]             thr_ff;
    logic                   resp_valid_ff;
    logic                   nxt_resp_valid;
    logic [7:0]             resp_data_ff;
    logic [7:0]             nxt_resp_data;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire logic [7:0] wake_src  = param_ff[IDX_WAKE_SRC];
    wire logic [7:0] wake_low  = param_ff[IDX_WAKE_CFG
                                          + OFS_POWER_CONTROL_LOW];
    wire logic [7:0] entry_low = param_ff[IDX_ENTRY
                                          + OFS_POWER_CONTROL_LOW];
    wire logic [7:0] entry_hi  = param_ff[IDX_ENTRY
                                          + OFS_POWER_CONTROL_HIGH];
    wire logic [7:0] wake_hi   = param_ff[IDX_WAKE_CFG
                                          + OFS_POWER_CONTROL_HIGH];
    wire logic [7:0] leave_low = param_ff[IDX_LEAVE
                                          + OFS_POWER_CONTROL_LOW];
    wire logic [7:0] leave_hi  = param_ff[IDX_LEAVE
                                          + OFS_POWER_CONTROL_HIGH];
    wire logic       in_idle   = (state_ff != ST_OFF)
                               && (state_ff != ST_LEAVE);
    wire logic       param_ok  = PARAM_WE && (state_ff == ST_OFF)
                               && (32'(PARAM_IDX) < PARAM_COUNT);

    // Prescaled slow tick; divider resets on each start
    wire logic [1:0] presc_sel = wake_src[WS_PRESC_HI:WS_PRESC_LO];
    wire logic [2:0] pmask     = presc_mask(presc_sel);
    wire logic       pre_tick  = SLOW_TICK
                               && ((presc_ff & pmask) == pmask);

    // Only the upper six bits of level and thresholds compare
    wire logic [5:0] meas6  = TAG_LEVEL[7:THR_LO];
    wire logic [5:0] low6   = param_ff[IDX_DAC_LOW][7:THR_LO];
    wire logic [5:0] high6  = param_ff[IDX_DAC_HIGH][7:THR_LO];
    wire logic       tag_hit = cmp_sel_ff ? (meas6 > high6)
                                          : (meas6 < low6);

    // Live wake sources, each gated by its own enable
    wire logic [4:0] src_now = {!SERIAL_SLAVE_SELECT_PIN_N,
                                !IRQ_IN_N,
                                FIELD_DETECT,
                                (state_ff == ST_BURST) && TAG_VALID
                                    && tag_hit,
                                1'b0};
    wire logic [4:0] evt_now = in_idle
                             ? (src_now & wake_src[WS_SLAVE_SEL:
                                                   WS_TIMEOUT])
                             : 5'h00;

    // Stage targets
    wire logic [SLEEP_CNT_W-1:0] sleep_end =
        sleep_target(param_ff[IDX_PERIOD]);
    wire logic [SLEEP_CNT_W-1:0] osc_end =
        SLEEP_CNT_W'(param_ff[IDX_OSC_START]);
    wire logic [SLEEP_CNT_W-1:0] dac_end =
        SLEEP_CNT_W'(param_ff[IDX_DAC_START]);
    wire logic [SLEEP_CNT_W-1:0] swing_end =
        SLEEP_CNT_W'(param_ff[IDX_SWING]);
    wire logic [TRIAL_W-1:0]     trial_max =
        param_ff[IDX_MAX_TRIAL][TRIAL_W-1:0];
    wire logic [SLEEP_CNT_W-1:0] cnt_inc = cnt_ff + 1'b1;
    // Burst ends at the edge that takes the last carrier tick
    wire logic                   burst_done =
        CARRIER_TICK ? (cnt_inc >= swing_end) : (cnt_ff >= swing_end);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // A live source preempts any stage, so a wake is never late
    always_comb begin
        nxt_state      = state_ff;
        nxt_cnt        = cnt_ff;
        nxt_trial      = trial_ff;
        nxt_cfg_low    = cfg_low_ff;
        nxt_cfg_high   = cfg_high_ff;
        nxt_cmp_sel    = cmp_sel_ff;
        nxt_evt        = evt_ff | evt_now;
        nxt_resp_valid = 1'b0;
        nxt_resp_data  = resp_data_ff;
        case (state_ff)
            ST_OFF: begin
                if (START) begin
                    nxt_evt      = 5'h00;
                    nxt_cnt      = '0;
                    nxt_trial    = '0;
                    nxt_cfg_low  = entry_low;
                    nxt_cfg_high = entry_hi;
                    nxt_state    = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (pre_tick) begin
                    nxt_cnt = cnt_inc;
                    if (cnt_inc >= sleep_end) begin
                        nxt_cnt      = '0;
                        nxt_cfg_low  = wake_low;
                        nxt_cfg_high = wake_hi;
                        nxt_state    = ST_OSC_WAIT;
                    end
                end
            end
            ST_OSC_WAIT: begin
                if (cnt_ff >= osc_end) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_DAC_WAIT;
                end else if (SLOW_TICK) begin
                    nxt_cnt = cnt_inc;
                end
            end
            ST_DAC_WAIT: begin
                if (cnt_ff >= dac_end) begin
                    nxt_cnt     = '0;
                    nxt_cmp_sel = cfg_low_ff[CTL_COMPARE_IDX];
                    nxt_state   = ST_BURST;
                end else if (SLOW_TICK) begin
                    nxt_cnt = cnt_inc;
                end
            end
            ST_BURST: begin
                if (TAG_VALID) begin
                    nxt_cmp_sel = !cmp_sel_ff;
                end
                if (CARRIER_TICK) begin
                    nxt_cnt = cnt_inc;
                end
                if (burst_done) begin
                    nxt_cnt = '0;
                    if (trial_ff >= trial_max) begin
                        nxt_evt[WS_TIMEOUT] =
                            wake_src[WS_TIMEOUT];
                    end
                    if (trial_ff >= trial_max
                        && !wake_src[WS_TIMEOUT]) begin
                        nxt_trial = '0;
                    end else if (trial_ff < trial_max) begin
                        nxt_trial = trial_ff + 1'b1;
                    end
                    nxt_cfg_low  = entry_low;
                    nxt_cfg_high = entry_hi;
                    nxt_state    = ST_SLEEP;
                end
            end
            ST_LEAVE: begin
                nxt_cfg_low    = leave_low;
                nxt_cfg_high   = leave_hi;
                nxt_resp_valid = 1'b1;
                nxt_resp_data  = {wake_src[WS_PRESC_HI:WS_KEEP_LO],
                                  evt_ff};
                nxt_state      = ST_OFF;
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
        if (in_idle && (nxt_evt != 5'h00)) begin
            nxt_state = ST_LEAVE;
        end
    end

    // State and counters
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= ST_OFF;
            cnt_ff   <= '0;
            trial_ff <= '0;
            evt_ff   <= 5'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            trial_ff <= nxt_trial;
            evt_ff   <= nxt_evt;
        end
    end

    // Slow oscillator divider; cleared at start for a clean phase
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            presc_ff <= 3'h0;
        end else if (state_ff == ST_OFF) begin
            presc_ff <= 3'h0;
        end else if (SLOW_TICK) begin
            presc_ff <= presc_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Parameter store
    // ------------------------------------------------------------
    // Writes refused while idle runs; exit writes back the source
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < PARAM_COUNT; i++) begin
                param_ff[i] <= RST_PARAM;
            end
            param_ff[IDX_WAKE_SRC + OFS_WAKE_SOURCE_SELECT
                     - OFS_WAKE_SOURCE_SELECT] <= RST_WAKE_SRC;
        end else if (param_ok) begin
            param_ff[PARAM_IDX] <= PARAM_DATA;
        end else if (state_ff == ST_LEAVE) begin
            param_ff[IDX_WAKE_SRC] <= nxt_resp_data;
        end
    end

    // ------------------------------------------------------------
    // Power configuration and answer
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_low_ff    <= RST_PARAM;
            cfg_high_ff   <= RST_PARAM;
            cmp_sel_ff    <= 1'b0;
            rf_on_ff      <= 1'b0;
            thr_ff        <= 6'h00;
            resp_valid_ff <= 1'b0;
            resp_data_ff  <= RST_PARAM;
        end else begin
            cfg_low_ff    <= nxt_cfg_low;
            cfg_high_ff   <= nxt_cfg_high;
            cmp_sel_ff    <= nxt_cmp_sel;
            rf_on_ff      <= (nxt_state == ST_BURST);
            thr_ff        <= nxt_cmp_sel ? high6 : low6;
            resp_valid_ff <= nxt_resp_valid;
            resp_data_ff  <= nxt_resp_data;
        end
    end

    // Outputs straight from the applied configuration and state registers
    assign BUSY                     = (state_ff != ST_OFF);
    assign SLOW_OSCILLATOR_EN       = cfg_low_ff[CTL_SLOW_OSC];
    assign FAST_OSCILLATOR_EN       = cfg_low_ff[CTL_FAST_OSC];
    assign ANALOGUE_SUPPLY_ENABLE   = cfg_low_ff[CTL_ANALOGUE];
    assign HIBERNATE                = cfg_low_ff[CTL_HIBERNATE];
    assign SLEEP                    = cfg_low_ff[CTL_SLEEP];
    assign FIELD_DETECTOR_EN        = cfg_high_ff[CTH_FIELD_DET];
    assign CURRENT_REFERENCE_ENABLE = cfg_high_ff[CTH_CURRENT_REF];
    assign RF_ON                    = rf_on_ff;
    assign COMPARE_SEL              = cmp_sel_ff;
    assign DAC_THRESHOLD            = thr_ff;
    assign RESP_VALID               = resp_valid_ff;
    assign RESP_DATA                = resp_data_ff;

endmodule

// >>> bench/idle_wakeup_properties.sv
`timescale 1ns/1ps
module idle_wakeup_properties
    import idle_wakeup_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic       PARAM_WE,
    input wire logic [3:0] PARAM_IDX,
    input wire logic [7:0] PARAM_DATA,
    input wire logic       START,
    input wire logic       SLOW_TICK,
    input wire logic       CARRIER_TICK,
    input wire logic       BUSY,
    input wire logic       SLEEP,
    input wire logic       HIBERNATE,
    input wire logic       RF_ON,
    input wire logic       COMPARE_SEL,
    input wire logic [5:0] DAC_THRESHOLD,
    input wire logic       RESP_VALID,
    input wire logic [7:0] RESP_DATA
);
    // --------
    // Shadow parameters and phase counters
    // --------
    logic [7:0]  prm_ff [PARAM_COUNT];
    logic [20:0] slow_cnt_ff;
    logic [8:0]  car_cnt_ff;
    wire         take = PARAM_WE && !BUSY && PARAM_IDX < 4'hE;
    wire  [7:0]  ent  = prm_ff[IDX_ENTRY];
    wire  [7:0]  per  = prm_ff[IDX_PERIOD];
    wire  [7:0]  lo   = prm_ff[IDX_DAC_LOW];
    wire  [7:0]  hi   = prm_ff[IDX_DAC_HIGH];
    wire  [7:0]  swg  = prm_ff[IDX_SWING];

    // Writes made while busy are dropped, so the copy skips them too
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < PARAM_COUNT; i++) prm_ff[i] <= RST_PARAM;
        end else if (take) begin
            prm_ff[PARAM_IDX] <= PARAM_DATA;
        end
    end

    // Raw slow ticks give only a floor, the prescaler may stretch them
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            slow_cnt_ff <= '0;
            car_cnt_ff  <= '0;
        end else begin
            slow_cnt_ff <= SLEEP ? slow_cnt_ff + 21'(SLOW_TICK) : '0;
            car_cnt_ff  <= RF_ON ? car_cnt_ff + 9'(CARRIER_TICK) : '0;
        end
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence start_taken;
        START && !BUSY;
    endsequence

    sequence burst_end;
        $fell(RF_ON) && BUSY;
    endsequence

    // A live source may cut a burst short; the answer then names it
    sequence burst_cut;
        (int'(car_cnt_ff) < int'(swg)) ##1
            (RESP_VALID && RESP_DATA[WS_SLAVE_SEL:WS_TAG] != 4'h0);
    endsequence

    resp_on_exit_a: assert property (
        RESP_VALID |-> !BUSY && $past(BUSY))
        else $error("answer without idle exit");
    resp_pulse_a: assert property (RESP_VALID |=> !RESP_VALID)
        else $error("answer longer than one cycle");
    resp_source_a: assert property (
        RESP_VALID |-> RESP_DATA[4:0] != 5'h00)
        else $error("answer names no wake source");
    busy_exit_a: assert property ($fell(BUSY) |-> RESP_VALID)
        else $error("idle left without answer");
    start_busy_a: assert property (start_taken |=> BUSY)
        else $error("start not taken");
    entry_cfg_a: assert property (start_taken |=>
        SLEEP == ent[CTL_SLEEP] && HIBERNATE == ent[CTL_HIBERNATE])
        else $error("entry state wrong");
    rf_busy_a: assert property (RF_ON |-> BUSY)
        else $error("carrier on outside idle");
    burst_len_a: assert property (burst_end |->
        int'(car_cnt_ff) == int'(swg) or burst_cut)
        else $error("burst length wrong");
    thresh_sel_a: assert property (RF_ON |-> DAC_THRESHOLD ==
        (COMPARE_SEL ? hi[7:2] : lo[7:2])) else $error("threshold wrong");
    sleep_len_a: assert property ($fell(SLEEP) && BUSY |->
        int'(slow_cnt_ff) + 2 >= 256 * (int'(per) + 2))
        else $error("sleep too short");
endmodule

bind idle_wakeup_controller
    idle_wakeup_properties u_idle_wakeup_properties (
    .MCLK, .RST_N, .PARAM_WE, .PARAM_IDX, .PARAM_DATA, .START, .SLOW_TICK,
    .CARRIER_TICK, .BUSY, .SLEEP, .HIBERNATE, .RF_ON, .COMPARE_SEL,
    .DAC_THRESHOLD, .RESP_VALID, .RESP_DATA
);

// >>> bench/idle_host_model.sv
`timescale 1ns/1ps
module idle_host_model
    import idle_wakeup_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RESP_VALID,
    input  wire logic [7:0] RESP_DATA,
    output logic            PARAM_WE,
    output logic [3:0]      PARAM_IDX,
    output logic [7:0]      PARAM_DATA,
    output logic            START
);
    logic [7:0] resp_q;
    int         resp_cnt;

    // Quiet lines at time zero
    initial begin
        PARAM_WE   = 1'b0;
        PARAM_IDX  = 4'hF;
        PARAM_DATA = 8'h00;
        START      = 1'b0;
        resp_cnt   = 0;
    end

    // Answer is taken at the edge where it is flagged
    always @(posedge MCLK) begin
        if (RESP_VALID === 1'b1) begin
            resp_q   <= RESP_DATA;
            resp_cnt <= resp_cnt + 1;
        end
    end

    // One byte; data is inverted once released so stale values never match
    task automatic put(input logic [3:0] idx, input logic [7:0] d);
        @(posedge MCLK);
        PARAM_WE   <= 1'b1;
        PARAM_IDX  <= idx;
        PARAM_DATA <= d;
        @(posedge MCLK);
        PARAM_WE   <= 1'b0;
        PARAM_IDX  <= 4'hF;
        PARAM_DATA <= ~d;
    endtask

    // Whole set, first byte first; reserved and mandatory bits fixed here
    task automatic load(input logic [111:0] cmd);
        logic [7:0] b;
        for (int i = 0; i < PARAM_COUNT; i++) begin
            b = cmd[111 - 8 * i -: 8];
            case (i)
                0:       b = (b & 8'hDF) | 8'h08;
                1, 5:    b = (b & 8'hBF) | {4'h0, b[4], 3'h0};
                2, 6:    b = b & 8'h02;
                3:       b = (b & 8'hBF) | 8'h38;
                4:       b = (b & 8'h02) | 8'h01;
                13:      b = b & 8'h1F;
                default: b = b;
            endcase
            put(4'(i), b);
        end
    endtask

    // Single start pulse
    task automatic go();
        @(posedge MCLK);
        START <= 1'b1;
        @(posedge MCLK);
        START <= 1'b0;
    endtask
endmodule

// >>> bench/idle_wakeup_controller_tb_top.sv
`timescale 1ns/1ps
module idle_wakeup_controller_tb_top;
    import idle_wakeup_pkg::*;
    logic       MCLK, RST_N, SLOW_TICK, CARRIER_TICK, TAG_VALID;
    logic       PARAM_WE, START, BUSY, RF_ON, COMPARE_SEL, RESP_VALID;
    logic       SLOW_OSCILLATOR_EN, FAST_OSCILLATOR_EN, HIBERNATE, SLEEP;
    logic       ANALOGUE_SUPPLY_ENABLE, FIELD_DETECTOR_EN;
    logic       CURRENT_REFERENCE_ENABLE;
    logic [3:0] PARAM_IDX;
    logic [7:0] PARAM_DATA, RESP_DATA, TAG_LEVEL;
    logic [5:0] DAC_THRESHOLD;
    logic [4:0] live;
    wire        FIELD_DETECT = live[2];
    wire        IRQ_IN_N = !live[3];
    wire        SERIAL_SLAVE_SELECT_PIN_N = !live[4];
    int         err_count, samples_checked, slp_n, bursts, rf_n;

    idle_wakeup_controller u_idle_wakeup_controller (
        .MCLK, .RST_N, .PARAM_WE, .PARAM_IDX, .PARAM_DATA, .START,
        .SLOW_TICK, .CARRIER_TICK, .SERIAL_SLAVE_SELECT_PIN_N, .IRQ_IN_N,
        .FIELD_DETECT, .TAG_VALID, .TAG_LEVEL, .BUSY, .SLOW_OSCILLATOR_EN,
        .FAST_OSCILLATOR_EN, .ANALOGUE_SUPPLY_ENABLE, .HIBERNATE, .SLEEP,
        .FIELD_DETECTOR_EN, .CURRENT_REFERENCE_ENABLE, .RF_ON, .COMPARE_SEL,
        .DAC_THRESHOLD, .RESP_VALID, .RESP_DATA
    );

    idle_host_model u_idle_host_model (
        .MCLK, .RESP_VALID, .RESP_DATA, .PARAM_WE, .PARAM_IDX, .PARAM_DATA,
        .START
    );

    // --------
    // Checking helpers
    // --------
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic chk_in(input string n, input int l, input int h,
                          input int g);
        samples_checked++;
        if (g < l || g > h) begin
            err_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", n, l, h, g);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bounded wait for one answer; tallies first sleep, bursts and carrier time
    task automatic wait_exit(input int lim);
        int   n0;
        logic rf_q;
        n0 = u_idle_host_model.resp_cnt;
        rf_q = 1'b0;
        slp_n = 0;
        bursts = 0;
        rf_n = 0;
        for (int i = 0; i < lim && u_idle_host_model.resp_cnt == n0; i++) begin
            @(posedge MCLK);
            #1;
            if (SLEEP === 1'b1 && bursts == 0) slp_n++;
            if (RF_ON === 1'b1 && !rf_q) bursts++;
            if (RF_ON === 1'b1) rf_n++;
            rf_q = RF_ON;
        end
        chk("answers", 1, u_idle_host_model.resp_cnt - n0);
    endtask

    // --------
    // Scenarios
    // --------
    // Timeout only; field and select held active but not enabled
    task automatic run_timeout(input logic [1:0] p, input logic [7:0] m);
        live <= 5'h14;
        u_idle_host_model.load({p, 6'h01, 32'h21003801, 16'h1800,
                                32'h00020254, 8'h60, 8'h04, m});
        u_idle_host_model.go();
        wait_exit(20000);
        chk_in("sleep", (512 << p) - 3, (512 << p) + 2, slp_n);
        chk("bursts", m + 1, bursts);
        chk("carrier", 4 * (m + 1), rf_n);
        chk("resp", {p, 1'b0, 5'h01}, u_idle_host_model.resp_q);
        chk("leave", 5'h0C, {SLOW_OSCILLATOR_EN, FAST_OSCILLATOR_EN,
            ANALOGUE_SUPPLY_ENABLE, SLEEP, CURRENT_REFERENCE_ENABLE});
        live <= 5'h00;
    endtask

    // Tag pulse during the burst
    task automatic pulse(input logic [7:0] l);
        @(posedge MCLK);
        TAG_VALID <= 1'b1;
        TAG_LEVEL <= l;
        @(posedge MCLK);
        TAG_VALID <= 1'b0;
        @(posedge MCLK);
        #1;
    endtask

    // One live source enabled; a write while busy must be dropped
    task automatic run_source(input int k, input logic sel);
        logic [4:0] ev;
        ev = 5'(1 << k);
        u_idle_host_model.load({3'h0, ev, 16'h2502, sel, 15'h3801, 16'h1800,
                                32'h00020254, 8'h60, 8'h40, 8'h00});
        u_idle_host_model.go();
        #1;
        chk("entry", 2'h3, {HIBERNATE, FIELD_DETECTOR_EN});
        u_idle_host_model.put(IDX_WAKE_SRC, 8'hE8);
        if (k == 1) begin
            for (int i = 0; i < 2000 && RF_ON !== 1'b1; i++) begin
                @(posedge MCLK);
                #1;
            end
            chk("wake", 3'h7, {FAST_OSCILLATOR_EN, ANALOGUE_SUPPLY_ENABLE,
                CURRENT_REFERENCE_ENABLE});
            chk("thr0", {sel, sel ? 6'h18 : 6'h15},
                {COMPARE_SEL, DAC_THRESHOLD});
            pulse(sel ? 8'h63 : 8'h57);
            chk("thr1", {!sel, sel ? 6'h15 : 6'h18},
                {COMPARE_SEL, DAC_THRESHOLD});
            pulse(sel ? 8'h53 : 8'h67);
        end else begin
            repeat (20) @(posedge MCLK);
            live <= ev;
        end
        wait_exit(12);
        chk("resp", {3'h0, ev}, u_idle_host_model.resp_q);
        live <= 5'h00;
    endtask

    // --------
    // Clock, sequence and watchdog
    // --------
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // Ticks run every cycle so that counts map straight onto cycles
    initial begin
        RST_N = 1'b0;
        SLOW_TICK = 1'b1;
        CARRIER_TICK = 1'b1;
        TAG_VALID = 1'b0;
        TAG_LEVEL = 8'h00;
        live = 5'h00;
        err_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        for (int p = 0; p < 4; p++) run_timeout(2'(p), 8'h00);
        run_timeout(2'h0, 8'h01);
        run_source(1, 1'b0);
        run_source(1, 1'b1);
        for (int k = 2; k < 5; k++) run_source(k, 1'b0);
        wrap_up();
    end

    // Planned run is near 10200 cycles
    initial begin
        repeat (60000) @(posedge MCLK);
        err_count++;
        wrap_up();
    end
endmodule
